// *** verilog/ssdq_pkg.sv ***
// Package of constants and types for the segment, s-i-b and query decoder.
// Notes on behaviour
// - Segment select 000..101 pick extra, code, stack, data, third, fourth.
// - Scale code 00, 01, 10, 11 multiply the index by 1, 2, 4, 8.
// - Scaled index is the index register times scale, added into offset.
// - Index code picks a general register; code 100 adds no index.
// - Mode comes from bits 7:6 of mode byte, base from s-i-b 2:0.
// - Mode 00 adds base; base 100 uses stack, base 101 uses dword disp.
// - Modes 01 and 10 add byte or dword displacement; bases 100, 101 stack.
// - Register-or-memory 100 with mode other than 11 means s-i-b byte.
// - Opcode 0FA2 is the identification query instruction.
// - Flags register bit 21 is writable to show the query exists.
// - Accumulator picks the level; results go to four general registers.
// - Levels 0..2 and 80000000h..80000005h are answered; 80000002h..80000004h share the name word, 80000005h repeats level 2.
// - Level zero returns 2 in the accumulator as highest standard level.
// - Level zero puts vendor string in base_b, data_d, count_reg.
// - Level one returns identity in accumulator, base_b and count reserved.
// - Level one packs stepping 3:0, model 7:4, family 11:8, type 15:12.
package ssdq_pkg;
  localparam logic [7:0] REG_GPR_BASE = 8'h00;
  localparam logic [7:0] REG_MODRM = 8'h20;
  localparam logic [7:0] REG_SIB = 8'h24;
  localparam logic [7:0] REG_DISP = 8'h28;
  localparam logic [7:0] REG_SEGSEL = 8'h2C;
  localparam logic [7:0] REG_OPCODE = 8'h30;
  localparam logic [7:0] REG_FLAGS = 8'h34;
  localparam logic [7:0] REG_CMD = 8'h38;
  localparam logic [7:0] REG_STATUS = 8'h3C;
  localparam logic [7:0] REG_EA = 8'h40;
  localparam logic [7:0] REG_SEG = 8'h44;
  localparam logic [7:0] GPR_SPAN_MASK = 8'hE0;
  localparam int GPR_IDX_MSB = 4;
  localparam int GPR_IDX_LSB = 2;
  localparam int MOD_MSB = 7;
  localparam int MOD_LSB = 6;
  localparam int RM_MSB = 2;
  localparam int SS_MSB = 7;
  localparam int SS_LSB = 6;
  localparam int IDX_MSB = 5;
  localparam int IDX_LSB = 3;
  localparam int BASE_MSB = 2;
  localparam logic [2:0] GPR_ACC = 3'h0;
  localparam logic [2:0] GPR_COUNT = 3'h1;
  localparam logic [2:0] GPR_DATA = 3'h2;
  localparam logic [2:0] GPR_BASE = 3'h3;
  localparam logic [2:0] GPR_STACK = 3'h4;
  localparam logic [2:0] GPR_FRAME = 3'h5;
  localparam logic [2:0] SEG_EXTRA = 3'h0;
  localparam logic [2:0] SEG_CODE = 3'h1;
  localparam logic [2:0] SEG_STACK = 3'h2;
  localparam logic [2:0] SEG_DATA = 3'h3;
  localparam logic [2:0] SEG_THIRD = 3'h4;
  localparam logic [2:0] SEG_FOURTH = 3'h5;
  localparam logic [1:0] MOD_NODISP = 2'h0;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISP32 = 2'h2;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [2:0] RM_SIB = 3'h4;
  localparam logic [2:0] RM_DISP_ONLY = 3'h5;
  localparam logic [2:0] INDEX_NONE = 3'h4;
  localparam logic [1:0] SS_X1 = 2'h0;
  localparam logic [1:0] SS_X2 = 2'h1;
  localparam logic [1:0] SS_X4 = 2'h2;
  localparam logic [1:0] SS_X8 = 2'h3;
  localparam logic [4:0] SHIFT_X1 = 5'h00;
  localparam logic [4:0] SHIFT_X2 = 5'h01;
  localparam logic [4:0] SHIFT_X4 = 5'h02;
  localparam logic [4:0] SHIFT_X8 = 5'h03;
  localparam logic [15:0] OPCODE_QUERY = 16'h0FA2;
  localparam logic [31:0] LVL_STD_MAX = 32'h0000_0002;
  localparam logic [31:0] LVL_EXT_BASE = 32'h8000_0000;
  localparam logic [31:0] LVL_EXT_MAX = 32'h8000_0005;
  localparam logic [3:0] ROM_STD0 = 4'h0;
  localparam logic [3:0] ROM_STD1 = 4'h1;
  localparam logic [3:0] ROM_STD2 = 4'h2;
  localparam logic [3:0] ROM_EXT0 = 4'h3;
  localparam logic [3:0] ROM_EXT1 = 4'h4;
  localparam logic [3:0] ROM_EXT5 = 4'h8;
  localparam logic [3:0] ROM_NONE = 4'h9;
  localparam logic [31:0] RET_MAX_STD = 32'h0000_0002;
  localparam logic [31:0] RET_MAX_EXT = 32'h8000_0005;
  // Vendor words and name word are arbitrary neutral values.
  localparam logic [31:0] VENDOR_W1 = 32'h5644_5231;
  localparam logic [31:0] VENDOR_W2 = 32'h5644_5232;
  localparam logic [31:0] VENDOR_W3 = 32'h5644_5233;
  localparam logic [31:0] NAME_WORD = 32'h4E41_4D45;
  localparam logic [3:0] ID_STEPPING = 4'h0;
  localparam logic [3:0] ID_MODEL = 4'h4;
  localparam logic [3:0] ID_FAMILY = 4'h5;
  localparam logic [3:0] ID_TYPE = 4'h0;
  localparam logic [31:0] STD_FEATURES = 32'h0080_8131;
  localparam logic [31:0] EXT_FEATURES = 32'h0000_0001;
  localparam logic [31:0] TLB_INFO = 32'h0000_7001;
  localparam logic [31:0] L1_INFO = 32'h0000_0080;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam int FLAG_QUERY_BIT = 21;
  localparam logic [31:0] FLAGS_WR_MASK = 32'h0020_0000;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
  localparam int CMD_AGEN_BIT = 0;
  localparam int CMD_EXEC_BIT = 1;
  localparam int ST_MEM_VALID = 0;
  localparam int ST_SIB = 1;
  localparam int ST_EA_UNDEF = 2;
  localparam int ST_INV_OP = 3;
  localparam int ST_QUERY_DONE = 4;
  localparam int ST_BUSY = 5;
  localparam int SEGR_ADDR_LSB = 8;
  typedef enum logic [2:0] {
    SSDQ_IDLE = 3'b001,
    SSDQ_FETCH = 3'b010,
    SSDQ_WRITE = 3'b100
  } ssdq_state_e;
endpackage : ssdq_pkg

// *** verilog/ssdq_agu_if.sv ***
// Interface carrying operands and decode results to the address unit.
`timescale 1ns/1ns
interface ssdq_agu_if;
  logic [7:0] modrm;
  logic [7:0] sib;
  logic [31:0] disp;
  logic [2:0] segsel;
  logic [31:0] gpr [8];
  logic [31:0] ea;
  logic [2:0] addr_seg;
  logic [5:0] seg_onehot;
  logic seg_invalid;
  logic sib_needed;
  logic mem_valid;
  logic ea_undef;
  modport core (output modrm, sib, disp, segsel, gpr,
    input ea, addr_seg, seg_onehot, seg_invalid, sib_needed, mem_valid,
    ea_undef);
  modport agu (input modrm, sib, disp, segsel, gpr,
    output ea, addr_seg, seg_onehot, seg_invalid, sib_needed, mem_valid,
    ea_undef);
endinterface : ssdq_agu_if

// *** verilog/ssdq_agu.sv ***
// Combinational segment decode and effective address generation.
`timescale 1ns/1ns
module ssdq_agu (
  ssdq_agu_if.agu bus
);
  logic [1:0] mode;
  logic [2:0] rm;
  logic [1:0] ss;
  logic [2:0] index;
  logic [2:0] base;
  logic [4:0] shift;
  logic [31:0] scaled;
  logic [31:0] disp_term;
  logic [31:0] base_term;
  assign mode = bus.modrm[ssdq_pkg::MOD_MSB:ssdq_pkg::MOD_LSB];
  assign rm = bus.modrm[ssdq_pkg::RM_MSB:0];
  assign ss = bus.sib[ssdq_pkg::SS_MSB:ssdq_pkg::SS_LSB];
  assign index = bus.sib[ssdq_pkg::IDX_MSB:ssdq_pkg::IDX_LSB];
  assign base = bus.sib[ssdq_pkg::BASE_MSB:0];
  generate
    for (genvar s = 0; s < 6; s++) begin : g_seg
      assign bus.seg_onehot[s] = (bus.segsel == 3'(s));
    end
  endgenerate
  assign bus.seg_invalid = (bus.segsel > ssdq_pkg::SEG_FOURTH);
  assign bus.mem_valid = (mode != ssdq_pkg::MOD_REG);
  assign bus.sib_needed = bus.mem_valid && (rm == ssdq_pkg::RM_SIB);
  assign bus.ea_undef = bus.sib_needed && (index == ssdq_pkg::INDEX_NONE)
    && (ss != ssdq_pkg::SS_X1);
  always_comb begin
    case (ss)
      ssdq_pkg::SS_X1: shift = ssdq_pkg::SHIFT_X1;
      ssdq_pkg::SS_X2: shift = ssdq_pkg::SHIFT_X2;
      ssdq_pkg::SS_X4: shift = ssdq_pkg::SHIFT_X4;
      ssdq_pkg::SS_X8: shift = ssdq_pkg::SHIFT_X8;
      default: shift = ssdq_pkg::SHIFT_X1;
    endcase
  end
  // An absent index contributes nothing, whatever the scale says.
  assign scaled = (!bus.sib_needed || index == ssdq_pkg::INDEX_NONE) ?
    ssdq_pkg::ZERO_WORD : (bus.gpr[index] << shift);
  always_comb begin
    disp_term = ssdq_pkg::ZERO_WORD;
    base_term = bus.gpr[bus.sib_needed ? base : rm];
    bus.addr_seg = ssdq_pkg::SEG_DATA;
    case (mode)
      ssdq_pkg::MOD_NODISP: begin
        if (bus.sib_needed && base == ssdq_pkg::GPR_STACK) begin
          bus.addr_seg = ssdq_pkg::SEG_STACK;
        end
        if ((bus.sib_needed ? base : rm) == ssdq_pkg::RM_DISP_ONLY) begin
          base_term = ssdq_pkg::ZERO_WORD;
          disp_term = bus.disp;
        end
      end
      ssdq_pkg::MOD_DISP8, ssdq_pkg::MOD_DISP32: begin
        disp_term = (mode == ssdq_pkg::MOD_DISP8) ?
          {{24{bus.disp[7]}}, bus.disp[7:0]} : bus.disp;
        if ((bus.sib_needed && base == ssdq_pkg::GPR_STACK)
            || (bus.sib_needed ? base : rm) == ssdq_pkg::GPR_FRAME) begin
          bus.addr_seg = ssdq_pkg::SEG_STACK;
        end
      end
      default: base_term = ssdq_pkg::ZERO_WORD;
    endcase
    bus.ea = base_term + scaled + disp_term;
  end
endmodule : ssdq_agu

// *** verilog/ssdq_query_rom.sv ***
// Constant table of query results with a registered read port.
`timescale 1ns/1ns
module ssdq_query_rom (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic rd_in,
  input wire logic [3:0] index_in,
  output logic [127:0] data_out
);
  logic [127:0] word;
  // Word order is accumulator, base_b, count_reg, data_d from high to low.
  always_comb begin
    case (index_in)
      ssdq_pkg::ROM_STD0: word = {ssdq_pkg::RET_MAX_STD, ssdq_pkg::VENDOR_W1,
        ssdq_pkg::VENDOR_W3, ssdq_pkg::VENDOR_W2};
      ssdq_pkg::ROM_STD1, ssdq_pkg::ROM_EXT1: word = {16'h0000,
        ssdq_pkg::ID_TYPE, ssdq_pkg::ID_FAMILY, ssdq_pkg::ID_MODEL,
        ssdq_pkg::ID_STEPPING, ssdq_pkg::ZERO_WORD, ssdq_pkg::ZERO_WORD,
        (index_in == ssdq_pkg::ROM_STD1) ? ssdq_pkg::STD_FEATURES :
        ssdq_pkg::EXT_FEATURES};
      ssdq_pkg::ROM_STD2: word = {ssdq_pkg::TLB_INFO, ssdq_pkg::ZERO_WORD,
        ssdq_pkg::ZERO_WORD, ssdq_pkg::L1_INFO};
      ssdq_pkg::ROM_EXT0: word = {ssdq_pkg::RET_MAX_EXT, ssdq_pkg::ZERO_WORD,
        ssdq_pkg::ZERO_WORD, ssdq_pkg::ZERO_WORD};
      4'h5, 4'h6, 4'h7: word = {4{ssdq_pkg::NAME_WORD}};
      ssdq_pkg::ROM_EXT5: word = {ssdq_pkg::TLB_INFO, ssdq_pkg::ZERO_WORD,
        ssdq_pkg::ZERO_WORD, ssdq_pkg::L1_INFO};
      default: word = {4{ssdq_pkg::ZERO_WORD}};
    endcase
  end
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_out <= {4{ssdq_pkg::ZERO_WORD}};
    end else if (rd_in) begin
      data_out <= word;
    end
  end
endmodule : ssdq_query_rom

// *** verilog/ssdq_top.sv ***
// Top of the segment, s-i-b and identification query decoder.
`timescale 1ns/1ns
module ssdq_top (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out
);
  ssdq_agu_if agu_bus ();
  ssdq_pkg::ssdq_state_e state;
  ssdq_pkg::ssdq_state_e next_state;
  logic [31:0] gpr [8];
  logic [7:0] modrm;
  logic [7:0] sib;
  logic [31:0] disp;
  logic [2:0] segsel;
  logic [15:0] opcode;
  logic [31:0] flags;
  logic [31:0] ea;
  logic [2:0] addr_seg;
  logic [5:0] seg_onehot;
  logic mem_valid;
  logic sib_seen;
  logic ea_undef;
  logic inv_op;
  logic query_done;
  logic [3:0] rom_index;
  logic [127:0] rom_data;
  logic [31:0] level;
  logic cmd_wr;
  logic agen_go;
  logic exec_go;
  logic exec_query;
  logic status_wr;
  logic gpr_wr;
  logic [2:0] gpr_sel;
  logic busy;
  logic [31:0] next_rdata;

  assign cmd_wr = wr_in && addr_in == ssdq_pkg::REG_CMD;
  assign agen_go = cmd_wr && wdata_in[ssdq_pkg::CMD_AGEN_BIT];
  assign exec_go = cmd_wr && wdata_in[ssdq_pkg::CMD_EXEC_BIT];
  assign exec_query = exec_go && (state == ssdq_pkg::SSDQ_IDLE)
    && (opcode == ssdq_pkg::OPCODE_QUERY);
  assign status_wr = wr_in && addr_in == ssdq_pkg::REG_STATUS;
  assign gpr_wr = wr_in
    && (addr_in & ssdq_pkg::GPR_SPAN_MASK) == ssdq_pkg::REG_GPR_BASE;
  assign gpr_sel = addr_in[ssdq_pkg::GPR_IDX_MSB:ssdq_pkg::GPR_IDX_LSB];
  assign busy = state != ssdq_pkg::SSDQ_IDLE;
  assign level = gpr[ssdq_pkg::GPR_ACC];

  assign agu_bus.modrm = modrm;
  assign agu_bus.sib = sib;
  assign agu_bus.disp = disp;
  assign agu_bus.segsel = segsel;
  assign agu_bus.gpr = gpr;

  ssdq_agu u_agu (
    .bus(agu_bus)
  );

  // The level is mapped onto a dense table index before the lookup.
  always_comb begin
    if (level <= ssdq_pkg::LVL_STD_MAX) begin
      rom_index = level[3:0];
    end else if (level >= ssdq_pkg::LVL_EXT_BASE
        && level <= ssdq_pkg::LVL_EXT_MAX) begin
      rom_index = ssdq_pkg::ROM_EXT0 + level[3:0];
    end else begin
      rom_index = ssdq_pkg::ROM_NONE;
    end
  end

  ssdq_query_rom u_rom (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .rd_in(exec_query),
    .index_in(rom_index),
    .data_out(rom_data)
  );

  always_comb begin
    next_state = state;
    case (state)
      ssdq_pkg::SSDQ_IDLE: begin
        if (exec_query) begin
          next_state = ssdq_pkg::SSDQ_FETCH;
        end
      end
      ssdq_pkg::SSDQ_FETCH: next_state = ssdq_pkg::SSDQ_WRITE;
      ssdq_pkg::SSDQ_WRITE: next_state = ssdq_pkg::SSDQ_IDLE;
      default: next_state = ssdq_pkg::SSDQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= ssdq_pkg::SSDQ_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Results land in the WRITE state; a software write to a general
  // register in that same cycle loses, so the query result is never torn.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < 8; i++) begin
        gpr[i] <= ssdq_pkg::ZERO_WORD;
      end
    end else if (state == ssdq_pkg::SSDQ_WRITE) begin
      gpr[ssdq_pkg::GPR_ACC] <= rom_data[127:96];
      gpr[ssdq_pkg::GPR_BASE] <= rom_data[95:64];
      gpr[ssdq_pkg::GPR_COUNT] <= rom_data[63:32];
      gpr[ssdq_pkg::GPR_DATA] <= rom_data[31:0];
    end else if (gpr_wr) begin
      gpr[gpr_sel] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      modrm <= 8'h00;
      sib <= 8'h00;
      disp <= ssdq_pkg::ZERO_WORD;
      segsel <= ssdq_pkg::SEG_DATA;
      opcode <= 16'h0000;
    end else if (wr_in) begin
      case (addr_in)
        ssdq_pkg::REG_MODRM: modrm <= wdata_in[7:0];
        ssdq_pkg::REG_SIB: sib <= wdata_in[7:0];
        ssdq_pkg::REG_DISP: disp <= wdata_in;
        ssdq_pkg::REG_SEGSEL: segsel <= wdata_in[2:0];
        ssdq_pkg::REG_OPCODE: opcode <= wdata_in[15:0];
        default: ;
      endcase
    end
  end

  // Only the query-present bit is writable; the rest read as zero.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flags <= ssdq_pkg::FLAGS_RESET;
    end else if (wr_in && addr_in == ssdq_pkg::REG_FLAGS) begin
      flags <= wdata_in & ssdq_pkg::FLAGS_WR_MASK;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ea <= ssdq_pkg::ZERO_WORD;
      addr_seg <= ssdq_pkg::SEG_DATA;
      seg_onehot <= 6'h00;
      mem_valid <= 1'b0;
      sib_seen <= 1'b0;
      ea_undef <= 1'b0;
    end else if (agen_go) begin
      ea <= agu_bus.ea;
      addr_seg <= agu_bus.addr_seg;
      seg_onehot <= agu_bus.seg_onehot;
      mem_valid <= agu_bus.mem_valid;
      sib_seen <= agu_bus.sib_needed;
      ea_undef <= agu_bus.ea_undef;
    end
  end

  // Sticky flags clear by writing one; a new event in the clear cycle wins.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      inv_op <= 1'b0;
      query_done <= 1'b0;
    end else begin
      if (agen_go && agu_bus.seg_invalid) begin
        inv_op <= 1'b1;
      end else if (status_wr && wdata_in[ssdq_pkg::ST_INV_OP]) begin
        inv_op <= 1'b0;
      end
      if (state == ssdq_pkg::SSDQ_WRITE) begin
        query_done <= 1'b1;
      end else if (status_wr && wdata_in[ssdq_pkg::ST_QUERY_DONE]) begin
        query_done <= 1'b0;
      end
    end
  end

  always_comb begin
    next_rdata = ssdq_pkg::ZERO_WORD;
    if ((addr_in & ssdq_pkg::GPR_SPAN_MASK) == ssdq_pkg::REG_GPR_BASE) begin
      next_rdata = gpr[gpr_sel];
    end else begin
      case (addr_in)
        ssdq_pkg::REG_MODRM: next_rdata = {24'h00_0000, modrm};
        ssdq_pkg::REG_SIB: next_rdata = {24'h00_0000, sib};
        ssdq_pkg::REG_DISP: next_rdata = disp;
        ssdq_pkg::REG_SEGSEL: next_rdata = {29'h0000_0000, segsel};
        ssdq_pkg::REG_OPCODE: next_rdata = {16'h0000, opcode};
        ssdq_pkg::REG_FLAGS: next_rdata = flags;
        ssdq_pkg::REG_STATUS: begin
          next_rdata[ssdq_pkg::ST_MEM_VALID] = mem_valid;
          next_rdata[ssdq_pkg::ST_SIB] = sib_seen;
          next_rdata[ssdq_pkg::ST_EA_UNDEF] = ea_undef;
          next_rdata[ssdq_pkg::ST_INV_OP] = inv_op;
          next_rdata[ssdq_pkg::ST_QUERY_DONE] = query_done;
          next_rdata[ssdq_pkg::ST_BUSY] = busy;
        end
        ssdq_pkg::REG_EA: next_rdata = ea;
        ssdq_pkg::REG_SEG: begin
          next_rdata[5:0] = seg_onehot;
          next_rdata[ssdq_pkg::SEGR_ADDR_LSB +: 3] = addr_seg;
        end
        default: next_rdata = ssdq_pkg::ZERO_WORD;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe and are zero else.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= ssdq_pkg::ZERO_WORD;
    end else if (rd_in) begin
      rdata_out <= next_rdata;
    end else begin
      rdata_out <= ssdq_pkg::ZERO_WORD;
    end
  end

  a_flag_toggle: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    wr_in && addr_in == ssdq_pkg::REG_FLAGS |=>
    flags[ssdq_pkg::FLAG_QUERY_BIT]
    == $past(wdata_in[ssdq_pkg::FLAG_QUERY_BIT]))
    else $error("Query-present flag did not follow the write.");

  a_flag_rest_zero: assert property (@(posedge clk_in)
    disable iff (!rst_b_in)
    (flags & ~ssdq_pkg::FLAGS_WR_MASK) == ssdq_pkg::ZERO_WORD)
    else $error("Non-writable flag bits are set.");

  a_query_timing: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    exec_query |=> state == ssdq_pkg::SSDQ_FETCH
    ##1 state == ssdq_pkg::SSDQ_WRITE ##1 query_done)
    else $error("Query did not complete in three cycles.");

  a_other_opcode: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    exec_go && !busy && opcode != 16'h0FA2 |=>
    state == ssdq_pkg::SSDQ_IDLE)
    else $error("Non-query opcode started a query.");

  a_level0_max: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    exec_query && level == 32'h0000_0000 |-> ##3
    gpr[0] == 32'h0000_0002 && gpr[3] == ssdq_pkg::VENDOR_W1
    && gpr[2] == ssdq_pkg::VENDOR_W2 && gpr[1] == ssdq_pkg::VENDOR_W3)
    else $error("Level zero result is wrong.");

  a_level1_pack: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    exec_query && level == 32'h0000_0001 |-> ##3
    gpr[0] == 32'h0000_0540 && gpr[3] == 32'h0000_0000
    && gpr[1] == 32'h0000_0000)
    else $error("Level one identity is packed wrong.");

  a_ext_max: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    exec_query && level == 32'h8000_0000 |-> ##3
    gpr[0] == 32'h8000_0005)
    else $error("Extended maximum level is wrong.");

  a_seg_invalid: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    agen_go && segsel[2:1] == 2'b11 |=> inv_op && seg_onehot == 6'h00)
    else $error("Undefined segment select did not flag.");

  a_seg_decode: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    agen_go && segsel <= ssdq_pkg::SEG_FOURTH |=>
    seg_onehot == (6'h01 << $past(segsel)) && inv_op == $past(inv_op))
    else $error("Segment select decoded wrong.");

  // The byte is expected only for a memory operand whose code is 100.
  a_sib_expect: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    agen_go |=> sib_seen ==
    ($past(modrm[ssdq_pkg::MOD_MSB:ssdq_pkg::MOD_LSB]) != ssdq_pkg::MOD_REG
    && $past(modrm[ssdq_pkg::RM_MSB:0]) == ssdq_pkg::RM_SIB))
    else $error("Scale-index-base expectation is wrong.");

  a_sib_index: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    agen_go && modrm[7:6] == 2'b00 && modrm[2:0] == 3'h4
    && sib[5:3] != 3'h4 && sib[2:0] != 3'h5 |=>
    ea == $past(gpr[sib[2:0]]) + ($past(gpr[sib[5:3]]) << $past(sib[7:6])))
    else $error("Scaled-index address is wrong.");

  a_sib_stack: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    agen_go && modrm[2:0] == 3'h4 && modrm[7:6] != 2'b11
    && sib[2:0] == 3'h4 |=> sib_seen && addr_seg == 3'h2)
    else $error("Stack base did not select the stack segment.");

  a_read_window: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !$past(rd_in) |-> rdata_out == 32'h0000_0000)
    else $error("Read data outside the answer cycle.");
endmodule : ssdq_top

// *** dv/ssdq_top_tb.sv ***
// Self-checking bench of the segment, s-i-b and query decoder.
`timescale 1ns/1ns
module ssdq_top_tb;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rdata_out;
  logic [31:0] v;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  ssdq_top dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out));
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  // The ceiling is about fifteen times the length of the whole sequence.
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors = errors + 1;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    v = rdata_out;
  endtask : rd
  function automatic logic [31:0] gpr(input logic [2:0] i);
    return 32'h0100_0010 * (i + 1);
  endfunction : gpr
  task automatic seg();
    for (int s = 0; s < 8; s++) begin
      wr(8'h2C, 32'(s));
      wr(8'h38, 32'h0000_0001);
      rd(8'h44);
      chk({26'h0, v[5:0]}, (s < 6) ? 32'h0000_0001 << s : 0);
      rd(8'h3C);
      chk(32'(v[3]), 32'(s > 5));
    end
    wr(8'h3C, 32'h0000_0008);
    wr(8'h2C, 32'h0000_0003);
  endtask : seg
  task automatic ea(input logic [1:0] md, input logic [2:0] bs,
      input logic [2:0] ix, input logic [1:0] ss, input logic [31:0] dp);
    logic [31:0] e;
    logic [2:0] sg;
    logic un;
    un = (ix == 3'h4) && (ss != 2'h0);
    e = (md == 2'h0 && bs == 3'h5) ? dp : gpr(bs);
    if (ix != 3'h4) e = e + (gpr(ix) << ss);
    if (md == 2'h1) e = e + {{24{dp[7]}}, dp[7:0]};
    if (md == 2'h2) e = e + dp;
    sg = (bs == 3'h4 || (bs == 3'h5 && md != 2'h0)) ? 3'h2 : 3'h3;
    wr(8'h20, {24'h00_0000, md, 6'h04});
    wr(8'h24, {24'h00_0000, ss, ix, bs});
    wr(8'h28, dp);
    wr(8'h38, 32'h0000_0001);
    rd(8'h40);
    if (!un) chk(v, e);
    rd(8'h44);
    chk({29'h0, v[10:8]}, {29'h0, sg});
    rd(8'h3C);
    chk({29'h0, v[2:0]}, {29'h0, un, 2'h3});
  endtask : ea
  // Register operands and plain base-plus-displacement carry no s-i-b byte.
  task automatic nosib();
    wr(8'h20, 32'h0000_00C4);
    wr(8'h38, 32'h0000_0001);
    rd(8'h3C);
    chk({30'h0, v[1:0]}, 32'h0000_0000);
    wr(8'h20, 32'h0000_0045);
    wr(8'h28, 32'h0000_0080);
    wr(8'h38, 32'h0000_0001);
    rd(8'h40);
    chk(v, gpr(3'h5) + 32'hFFFF_FF80);
    rd(8'h44);
    chk({29'h0, v[10:8]}, 32'h0000_0002);
    rd(8'h3C);
    chk({30'h0, v[1:0]}, 32'h0000_0001);
  endtask : nosib
  task automatic q(input logic [31:0] lv, input logic [15:0] op,
      input logic [31:0] m, input logic [31:0] x, input logic dn);
    wr(8'h3C, 32'h0000_0018);
    wr(8'h00, lv);
    wr(8'h30, {16'h0000, op});
    wr(8'h38, 32'h0000_0002);
    // Four reads outlast the three-cycle query walk.
    for (int k = 0; k < 4; k++) begin
      rd(8'h3C);
    end
    chk(32'(v[4]), 32'(dn));
    rd(8'h00);
    chk(v & m, x);
  endtask : q
  initial begin
    repeat (20) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd(8'h2C);
    chk(v, 32'h0000_0003);
    wr(8'h34, 32'hFFFF_FFFF);
    rd(8'h34);
    chk(v, ssdq_pkg::FLAGS_WR_MASK);
    wr(8'h34, 32'h0000_0000);
    rd(8'h34);
    chk(v, 32'h0000_0000);
    wr(8'h48, 32'hFFFF_FFFF);
    rd(8'h48);
    chk(v, 32'h0000_0000);
    seg();
    for (int i = 0; i < 8; i++) begin
      wr(8'(i * 4), gpr(3'(i)));
    end
    for (int s = 0; s < 4; s++) begin
      ea(2'h0, 3'h0, 3'h1, 2'(s), 32'h0000_0000);
    end
    ea(2'h0, 3'h4, 3'h2, 2'h0, 32'h0000_0000);
    ea(2'h0, 3'h5, 3'h4, 2'h0, 32'h1234_5678);
    ea(2'h1, 3'h5, 3'h6, 2'h2, 32'h0000_0070);
    ea(2'h2, 3'h3, 3'h7, 2'h3, 32'h0001_0000);
    ea(2'h0, 3'h1, 3'h4, 2'h2, 32'h0000_0000);
    nosib();
    q(0, 16'h0FA2, '1, ssdq_pkg::RET_MAX_STD, 1'b1);
    rd(8'h0C);
    chk(v, ssdq_pkg::VENDOR_W1);
    rd(8'h08);
    chk(v, ssdq_pkg::VENDOR_W2);
    rd(8'h04);
    chk(v, ssdq_pkg::VENDOR_W3);
    q(1, 16'h0FA2, 32'h0000_FFFF, {16'h0000, ssdq_pkg::ID_TYPE,
      ssdq_pkg::ID_FAMILY, ssdq_pkg::ID_MODEL,
      ssdq_pkg::ID_STEPPING}, 1'b1);
    rd(8'h08);
    chk(v, ssdq_pkg::STD_FEATURES);
    q(2, 16'h0FA2, '1, ssdq_pkg::TLB_INFO, 1'b1);
    q(32'h8000_0000, 16'h0FA2, '1, ssdq_pkg::RET_MAX_EXT, 1'b1);
    q(32'h8000_0005, 16'h0FA2, '1, ssdq_pkg::TLB_INFO, 1'b1);
    q(3, 16'h0FA2, '1, 32'h0000_0000, 1'b1);
    q(1, 16'h0FA3, '1, 32'h0000_0001, 1'b0);
    end_sim();
  end
endmodule : ssdq_top_tb
